// ### design/pio_ports.sv
`timescale 1ns/100ps
`default_nettype none
// Four parallel ports behind the special-function bus. A bus cycle is three
// states: the request cycle, the read sample state and the write update state.
module pio_ports (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  output logic [7:0] sfr_rdata,
  output logic sfr_ack,
  input wire logic irq_zero_pin_enable,
  input wire logic stop_mode,
  input wire logic analog_input_disable,
  input wire logic [3:0] analog_channel_select,
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  input wire logic [6:0] port1_pin_in,
  output logic [6:0] port1_pin_out,
  output logic [6:0] port1_pin_oe,
  input wire logic [2:0] port2_pin_in,
  output logic [2:0] port2_pin_out,
  output logic [2:0] port2_pin_oe,
  input wire logic [7:0] port3_pin_in,
  output logic [7:0] port3_pin_out,
  output logic [7:0] port3_pin_oe,
  output logic port1_bit_one_pin_edge,
  output logic port2_bit_zero_pin_fall
);

  // Decodes the converter channel into a port 3 pin mask.
  function automatic logic [7:0] pio_chan_mask(input logic disable_n_a, input logic [3:0] chan);
    logic [7:0] m;
    m = 8'h00;
    if (!disable_n_a && !chan[3]) begin
      m = 8'h01 << chan[2:0];
    end
    return m;
  endfunction : pio_chan_mask

  // Picks bits of a where sel is set and bits of b elsewhere.
  function automatic logic [7:0] pio_merge(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] b);
    return (a & sel) | (b & ~sel);
  endfunction : pio_merge

  // Bus cycle state and the captured request.
  pio_pkg::pio_state_t st_q;
  logic [7:0] addr_q;
  logic is_rd_q;

  // Port registers.
  logic [7:0] port0_output_latch_q;
  logic [7:0] port0_drive_type_q;
  logic [6:0] port1_output_latch_q;
  logic [6:0] port1_direction_q;
  logic [2:0] port2_output_latch_q;
  logic [7:0] port3_output_latch_q;
  logic [7:0] port3_direction_q;

  // Previous pin levels for the edge detectors.
  logic port1_bit_one_pin_prev_q;
  logic port2_bit_zero_pin_prev_q;

  // Request accepted this cycle; requests while busy are simply dropped.
  logic req_take;
  logic wr_take;

  // Pins currently claimed by the converter.
  logic [7:0] analog_mask;

  // Read value assembled from pins and latches during the sample state.
  logic [7:0] rdata_d;

  // Forced releases for the shared-function pins.
  logic [6:0] port1_release;
  logic [2:0] port2_release;

  assign req_take = (st_q == pio_pkg::ST_IDLE) && (sfr_rd || sfr_wr);
  // A write wins when both strobes arrive together.
  assign wr_take = (st_q == pio_pkg::ST_IDLE) && sfr_wr;
  assign analog_mask = pio_chan_mask(analog_input_disable, analog_channel_select);

  // Interrupt-zero use of port 1 bit 0 turns it into a pure input.
  assign port1_release = {6'h00, irq_zero_pin_enable};
  // Port 2 bit 0 doubles as the stop-release input, so it floats in stop mode.
  assign port2_release = {2'h0, stop_mode};

  // Bus cycle sequencer: idle, read sample, write update, back to idle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= pio_pkg::ST_IDLE;
    end else begin
      unique case (st_q)
        pio_pkg::ST_IDLE: begin
          if (req_take) begin
            st_q <= pio_pkg::ST_READ_SAMPLE;
          end
        end
        pio_pkg::ST_READ_SAMPLE: begin
          st_q <= pio_pkg::ST_WRITE_UPDATE;
        end
        pio_pkg::ST_WRITE_UPDATE: begin
          st_q <= pio_pkg::ST_IDLE;
        end
        default: begin
          st_q <= pio_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Request capture; the address is held for the sample state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_q <= 8'h00;
      is_rd_q <= 1'b0;
    end else if (req_take) begin
      addr_q <= sfr_addr;
      is_rd_q <= !sfr_wr;
    end
  end

  // Port 0 latch and drive type. The latch is written at the request edge so
  // that the registered pin drivers show it in the write update state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port0_output_latch_q <= pio_pkg::RST_PORT0_LATCH;
      port0_drive_type_q <= pio_pkg::RST_PORT0_DRIVE;
    end else if (wr_take) begin
      if (sfr_addr == pio_pkg::OFF_PORT0_OUTPUT_LATCH) begin
        port0_output_latch_q <= sfr_wdata;
      end
      if (sfr_addr == pio_pkg::OFF_PORT0_DRIVE_TYPE) begin
        port0_drive_type_q <= sfr_wdata;
      end
    end
  end

  // Port 1 latch and direction; bit 7 of the bus has no storage.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port1_output_latch_q <= pio_pkg::RST_PORT1_LATCH;
      port1_direction_q <= pio_pkg::RST_PORT1_DIR;
    end else if (wr_take) begin
      if (sfr_addr == pio_pkg::OFF_PORT1_OUTPUT_LATCH) begin
        port1_output_latch_q <= sfr_wdata[6:0];
      end
      if (sfr_addr == pio_pkg::OFF_PORT1_DIRECTION) begin
        port1_direction_q <= sfr_wdata[6:0];
      end
    end
  end

  // Port 2 latch; only three bits exist.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port2_output_latch_q <= pio_pkg::RST_PORT2_LATCH;
    end else if (wr_take && (sfr_addr == pio_pkg::OFF_PORT2_OUTPUT_LATCH)) begin
      port2_output_latch_q <= sfr_wdata[2:0];
    end
  end

  // Port 3 latch and direction. The latch stores even for analog pins; the
  // drive stage is what keeps those pins quiet.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port3_output_latch_q <= pio_pkg::RST_PORT3_LATCH;
      port3_direction_q <= pio_pkg::RST_PORT3_DIR;
    end else if (wr_take) begin
      if (sfr_addr == pio_pkg::OFF_PORT3_OUTPUT_LATCH) begin
        port3_output_latch_q <= sfr_wdata;
      end
      if (sfr_addr == pio_pkg::OFF_PORT3_DIRECTION) begin
        port3_direction_q <= sfr_wdata;
      end
    end
  end

  // Read multiplexer. Pins are taken as they stand in the sample state, with no
  // input latch, so software must debounce slow or bouncing inputs itself.
  always_comb begin
    rdata_d = pio_pkg::UNMAPPED_READ;
    if (addr_q <= pio_pkg::SFR_LAST) begin
      unique case (addr_q)
        pio_pkg::OFF_PORT0_OUTPUT_LATCH: rdata_d = port0_output_latch_q;
        pio_pkg::OFF_PORT0_PIN_LEVELS: rdata_d = port0_pin_in;
        // Input bits read their pins, so a bit operation may rewrite them.
        pio_pkg::OFF_PORT1_OUTPUT_LATCH: rdata_d = {1'b0, port1_pin_in};
        pio_pkg::OFF_PORT2_OUTPUT_LATCH: rdata_d = {pio_pkg::PORT2_UPPER_FILL, port2_output_latch_q};
        pio_pkg::OFF_PORT2_PIN_LEVELS: rdata_d = {pio_pkg::PORT2_UPPER_FILL, port2_pin_in};
        // Analog pins report the latch, the rest their logic level.
        pio_pkg::OFF_PORT3_OUTPUT_LATCH: rdata_d = pio_merge(analog_mask, port3_output_latch_q, port3_pin_in);
        pio_pkg::OFF_PORT1_DIRECTION: rdata_d = {1'b0, port1_direction_q};
        pio_pkg::OFF_PORT3_DIRECTION: rdata_d = port3_direction_q;
        pio_pkg::OFF_PORT0_DRIVE_TYPE: rdata_d = port0_drive_type_q;
        default: rdata_d = pio_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Read data and acknowledge. Data is captured at the end of the sample state
  // and shown with the acknowledge during the write update state.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
      sfr_ack <= 1'b0;
    end else begin
      sfr_ack <= (st_q == pio_pkg::ST_READ_SAMPLE);
      if ((st_q == pio_pkg::ST_READ_SAMPLE) && is_rd_q) begin
        sfr_rdata <= rdata_d;
      end
    end
  end

  // Edge detectors. During reset the previous level tracks the pin so that
  // no false edge appears at release. Both detectors watch the pin itself, so
  // a pin driven as an output still raises its flag when its own value moves, both ways for port 1 bit 1 and downward for port 2 bit 0.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port1_bit_one_pin_prev_q <= port1_pin_in[1];
      port2_bit_zero_pin_prev_q <= port2_pin_in[0];
      port1_bit_one_pin_edge <= 1'b0;
      port2_bit_zero_pin_fall <= 1'b0;
    end else begin
      port1_bit_one_pin_prev_q <= port1_pin_in[1];
      port2_bit_zero_pin_prev_q <= port2_pin_in[0];
      port1_bit_one_pin_edge <= port1_pin_in[1] ^ port1_bit_one_pin_prev_q;
      port2_bit_zero_pin_fall <= port2_bit_zero_pin_prev_q & ~port2_pin_in[0];
    end
  end

  // Port 0: drive type 0 is open drain, 1 is push-pull.
  pio_pin_drive #(.WIDTH(pio_pkg::P0_W)) u_port0_drive (
    .core_clk(core_clk),
    .reset(reset),
    .latch(port0_output_latch_q),
    .drive_enable(8'hff),
    .open_drain(~port0_drive_type_q),
    .force_release(8'h00),
    .pin_out(port0_pin_out),
    .pin_oe(port0_pin_oe)
  );

  // Port 1: push-pull, enabled per bit by the direction register.
  pio_pin_drive #(.WIDTH(pio_pkg::P1_W)) u_port1_drive (
    .core_clk(core_clk),
    .reset(reset),
    .latch(port1_output_latch_q),
    .drive_enable(port1_direction_q),
    .open_drain(7'h00),
    .force_release(port1_release),
    .pin_out(port1_pin_out),
    .pin_oe(port1_pin_oe)
  );

  // Port 2: no direction register, so a latch bit of 1 releases the pin.
  pio_pin_drive #(.WIDTH(pio_pkg::P2_W)) u_port2_drive (
    .core_clk(core_clk),
    .reset(reset),
    .latch(port2_output_latch_q),
    .drive_enable(3'h0),
    .open_drain(3'h7),
    .force_release(port2_release),
    .pin_out(port2_pin_out),
    .pin_oe(port2_pin_oe)
  );

  // Port 3: direction enables drive, analog selection overrides everything.
  pio_pin_drive #(.WIDTH(pio_pkg::P3_W)) u_port3_drive (
    .core_clk(core_clk),
    .reset(reset),
    .latch(port3_output_latch_q),
    .drive_enable(port3_direction_q),
    .open_drain(8'h00),
    .force_release(analog_mask),
    .pin_out(port3_pin_out),
    .pin_oe(port3_pin_oe)
  );

  // Accepted read and write requests to one address.
  sequence s_rd(logic [7:0] a);
    (st_q == pio_pkg::ST_IDLE) && sfr_rd && !sfr_wr && (sfr_addr == a);
  endsequence

  sequence s_wr(logic [7:0] a);
    (st_q == pio_pkg::ST_IDLE) && sfr_wr && (sfr_addr == a);
  endsequence

  a_pin_sample_read: assert property (@(posedge core_clk) disable iff (reset)
    s_rd(pio_pkg::OFF_PORT0_PIN_LEVELS) |=> ##1 (sfr_ack && (sfr_rdata == $past(port0_pin_in))))
    else $error("Port 0 pin read did not return sampled pins.");

  a_latch_read_back: assert property (@(posedge core_clk) disable iff (reset)
    s_rd(pio_pkg::OFF_PORT0_OUTPUT_LATCH) |=> ##1 (sfr_rdata == $past(port0_output_latch_q)))
    else $error("Port 0 data read did not return the latch.");

  a_write_update_pins: assert property (@(posedge core_clk) disable iff (reset)
    s_wr(pio_pkg::OFF_PORT1_OUTPUT_LATCH) |=> ##1 (port1_pin_out == $past(sfr_wdata[6:0], 2)))
    else $error("Port 1 pins did not follow the write in the update state.");

  a_reset_values: assert property (@(posedge core_clk)
    $fell(reset) |-> (port0_output_latch_q == 8'hff) && (port0_drive_type_q == 8'h00) &&
      (port1_direction_q == 7'h00) && (port2_output_latch_q == 3'h7) && (port3_direction_q == 8'h00))
    else $error("Port registers wrong after reset.");

  a_open_drain_bit: assert property (@(posedge core_clk) disable iff (reset)
    $past(!port0_drive_type_q[0]) |-> (!port0_pin_out[0] && (port0_pin_oe[0] == !$past(port0_output_latch_q[0]))))
    else $error("Open-drain bit drove high or missed its low.");

  a_dir_drive_pin: assert property (@(posedge core_clk) disable iff (reset)
    $past(port3_direction_q[2] && !analog_mask[2]) |->
      (port3_pin_oe[2] && (port3_pin_out[2] == $past(port3_output_latch_q[2]))))
    else $error("Port 3 output bit not driving its latch.");

  a_irq_zero_release: assert property (@(posedge core_clk) disable iff (reset)
    $past(irq_zero_pin_enable) |-> !port1_pin_oe[0])
    else $error("Port 1 bit 0 driven while used as interrupt input.");

  a_stop_release_pin: assert property (@(posedge core_clk) disable iff (reset)
    $past(stop_mode) |-> !port2_pin_oe[0])
    else $error("Port 2 bit 0 driven in stop mode.");

  a_analog_no_drive: assert property (@(posedge core_clk) disable iff (reset)
    ##1 ((port3_pin_oe & $past(analog_mask)) == 8'h00))
    else $error("Analog-selected port 3 pin is driven.");

  a_port3_read_mix: assert property (@(posedge core_clk) disable iff (reset)
    s_rd(pio_pkg::OFF_PORT3_OUTPUT_LATCH) |=> ##1
      (sfr_rdata == pio_merge($past(analog_mask), $past(port3_output_latch_q), $past(port3_pin_in))))
    else $error("Port 3 read mixed latch and pins wrongly.");

  a_port2_upper_fill: assert property (@(posedge core_clk) disable iff (reset)
    s_rd(pio_pkg::OFF_PORT2_PIN_LEVELS) |=> ##1 (sfr_rdata[7:3] == 5'h1f))
    else $error("Port 2 upper bits not filled.");

  a_both_edges_flag: assert property (@(posedge core_clk) disable iff (reset)
    $changed(port1_pin_in[1]) |=> port1_bit_one_pin_edge)
    else $error("Port 1 bit 1 edge not flagged.");

  a_falling_edge_flag: assert property (@(posedge core_clk) disable iff (reset)
    ##1 (port2_bit_zero_pin_fall == ($past(port2_pin_in[0], 2) && !$past(port2_pin_in[0]))))
    else $error("Port 2 bit 0 fall flag wrong.");

  a_outside_space: assert property (@(posedge core_clk) disable iff (reset)
    (st_q == pio_pkg::ST_IDLE) && sfr_rd && !sfr_wr && (sfr_addr > 8'h3f) |=> ##1 (sfr_rdata == 8'h00))
    else $error("Address outside the special-function space answered.");

endmodule : pio_ports
`default_nettype wire

// ### design/pio_pkg.sv
// How it works
// - Registers decode inside SFR space 0x00 to 0x3f.
// - Outputs are latched; inputs read straight from pins.
// - Reads sample pins in the read sample state.
// - Writes change pins in the write update state.
// - Reset: port 0 latch ones, drive type zero.
// - Port 0 bits open-drain or push-pull per bit.
// - Port 0 data reads latch; pin register reads pins.
// - Port 1: seven bits, direction and latch reset zero.
// - Port 1 bit 0 is GPIO or interrupt zero.
// - Pin enable zero gives GPIO, one gives interrupt.
// - Port 1 bit 1 edges flag both directions.
// - Port 2: three bits, latch resets to ones.
// - Port 2 reads return undefined bits 7 to 3.
// - Stop mode floats port 2 bit 0.
// - Port 2 bit 0 falling edge flags interrupt.
// - Port 3 resets to digital inputs, analog disabled.
// - Analog-selected port 3 pins never drive.
// - Port 3 direction one drives its latch bit.
// - Analog pins read latch; others read pin level.
// - Port reads of input bits return pin levels; port 0 and port 2 data reads return the latch instead.
package pio_pkg;

  // Width of the special-function address bus and of its data.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Top of the special-function space; anything above is not ours.
  localparam logic [ADDR_W-1:0] SFR_LAST = 8'h3f;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFF_PORT0_OUTPUT_LATCH = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PORT1_OUTPUT_LATCH = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_PORT2_OUTPUT_LATCH = 8'h02;
  localparam logic [ADDR_W-1:0] OFF_PORT3_OUTPUT_LATCH = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_PORT1_DIRECTION = 8'h09;
  localparam logic [ADDR_W-1:0] OFF_PORT3_DIRECTION = 8'h0a;
  localparam logic [ADDR_W-1:0] OFF_PORT0_DRIVE_TYPE = 8'h0b;
  localparam logic [ADDR_W-1:0] OFF_PORT0_PIN_LEVELS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PORT2_PIN_LEVELS = 8'h0d;

  // Port widths.
  localparam int unsigned P0_W = 8;
  localparam int unsigned P1_W = 7;
  localparam int unsigned P2_W = 3;
  localparam int unsigned P3_W = 8;

  // Values after reset.
  localparam logic [7:0] RST_PORT0_LATCH = 8'hff;
  localparam logic [7:0] RST_PORT0_DRIVE = 8'h00;
  localparam logic [6:0] RST_PORT1_LATCH = 7'h00;
  localparam logic [6:0] RST_PORT1_DIR = 7'h00;
  localparam logic [2:0] RST_PORT2_LATCH = 3'h7;
  localparam logic [7:0] RST_PORT3_LATCH = 8'h00;
  localparam logic [7:0] RST_PORT3_DIR = 8'h00;

  // Value shown in the unimplemented upper bits of port 2 reads.
  localparam logic [4:0] PORT2_UPPER_FILL = 5'h1f;

  // Value returned for an address that holds no port register.
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Width of the converter channel select; codes 0 to 7 select one of the eight port 3 pins.
  localparam int unsigned CHAN_W = 4;

  // Bus cycle states: idle, then read sample, then write update.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ_SAMPLE = 3'b010,
    ST_WRITE_UPDATE = 3'b100
  } pio_state_t;

endpackage : pio_pkg

// ### design/pio_pin_drive.sv
`timescale 1ns/100ps
`default_nettype none
// Registered pin driver for one port. Each bit is either push-pull (drives the
// latch level when enabled) or open-drain (pulls low only while the latch is 0).
module pio_pin_drive #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] drive_enable,
  input wire logic [WIDTH-1:0] open_drain,
  input wire logic [WIDTH-1:0] force_release,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  // Combinational drive decision before the output flops.
  logic [WIDTH-1:0] out_d;
  logic [WIDTH-1:0] oe_d;

  // An open-drain bit only sinks current, so its data is always 0 and the
  // latch steers the enable; a forced release beats every other setting.
  always_comb begin
    out_d = latch & ~open_drain;
    oe_d = ~force_release & ((open_drain & ~latch) | (~open_drain & drive_enable));
  end

  // Output flops keep the pins glitch free; all pins float during reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= out_d;
      pin_oe <= oe_d;
    end
  end

endmodule : pio_pin_drive
`default_nettype wire

// ### test/pio_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// Far side of one port: an external driver on each pin and a pull-up on every line.
module pio_pin_model #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] ext_en,
  input wire logic [WIDTH-1:0] ext_val,
  output logic [WIDTH-1:0] level
);
  // Resolve each line; a released line floats up, so a stuck output enable shows.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (pin_oe[i]) begin
        level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        level[i] = ext_val[i];
      end else begin
        level[i] = 1'b1;
      end
    end
  end
endmodule : pio_pin_model
`default_nettype wire

// ### test/parallel_io_ports_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench: registers through the special-function bus, pins through models.
module parallel_io_ports_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_rd = 1'b0, sfr_wr = 1'b0, sfr_ack;
  logic irq_zero_pin_enable = 1'b0, stop_mode = 1'b0, analog_input_disable = 1'b1;
  logic [3:0] analog_channel_select = 4'h0;
  logic [7:0] port0_pin_out, port0_pin_oe, port3_pin_out, port3_pin_oe, lv0, lv3;
  logic [6:0] port1_pin_out, port1_pin_oe, lv1;
  logic [2:0] port2_pin_out, port2_pin_oe, lv2;
  logic port1_bit_one_pin_edge, port2_bit_zero_pin_fall;
  logic [7:0] e_en0 = 8'h00, e_en1 = 8'h00, e_en2 = 8'h00, e_en3 = 8'h00;
  logic [7:0] e_v0 = 8'h00, e_v1 = 8'h00, e_v2 = 8'h00, e_v3 = 8'h00;
  logic [7:0] cnt1 = 8'h00, cnt2 = 8'h00, c0, l, d, t, am;
  logic [15:0] seed = 16'hfdf3;
  int error_cnt = 0, n_tests = 0;

  // The clock toggles every half period of 50 ns.
  always #50 core_clk = ~core_clk;

  pio_ports dut_u (.core_clk, .reset, .sfr_addr, .sfr_wdata, .sfr_rd, .sfr_wr, .sfr_rdata, .sfr_ack,
    .irq_zero_pin_enable, .stop_mode, .analog_input_disable, .analog_channel_select,
    .port0_pin_in(lv0), .port0_pin_out, .port0_pin_oe, .port1_pin_in(lv1), .port1_pin_out, .port1_pin_oe,
    .port2_pin_in(lv2), .port2_pin_out, .port2_pin_oe, .port3_pin_in(lv3), .port3_pin_out, .port3_pin_oe,
    .port1_bit_one_pin_edge, .port2_bit_zero_pin_fall);
  pio_pin_model #(.WIDTH(8)) m0_u (.pin_oe(port0_pin_oe), .pin_out(port0_pin_out), .ext_en(e_en0),
    .ext_val(e_v0), .level(lv0));
  pio_pin_model #(.WIDTH(7)) m1_u (.pin_oe(port1_pin_oe), .pin_out(port1_pin_out), .ext_en(e_en1[6:0]),
    .ext_val(e_v1[6:0]), .level(lv1));
  pio_pin_model #(.WIDTH(3)) m2_u (.pin_oe(port2_pin_oe), .pin_out(port2_pin_out), .ext_en(e_en2[2:0]),
    .ext_val(e_v2[2:0]), .level(lv2));
  pio_pin_model #(.WIDTH(8)) m3_u (.pin_oe(port3_pin_oe), .pin_out(port3_pin_out), .ext_en(e_en3),
    .ext_val(e_v3), .level(lv3));

  // Edge pulses are counted as they stand, so a missing or doubled pulse shows.
  always @(posedge core_clk) begin
    if (port1_bit_one_pin_edge === 1'b1) cnt1 <= cnt1 + 8'h01;
    if (port2_bit_zero_pin_fall === 1'b1) cnt2 <= cnt2 + 8'h01;
  end

  // Sixteen-bit shift register for repeatable random values.
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd

  // Expected line level from drive enable, driven value and the external driver.
  function automatic logic [7:0] lev(input logic [7:0] oe, out, en, val);
    return (oe & out) | (~oe & en & val) | (~oe & ~en);
  endfunction : lev

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One bus cycle, request for one cycle only; returns in the cycle after the answer.
  // Software never uses read-modify-write, so plain writes stand alone.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
    int k;
    k = 0;
    sfr_addr = a;
    sfr_wdata = wd;
    sfr_wr = wr;
    sfr_rd = ~wr;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    while (sfr_ack !== 1'b1 && k < 4) begin
      @(negedge core_clk);
      k++;
    end
    if (k != 1) chk(8'h00, 8'h01);
    q = sfr_rdata;
    @(negedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b1, a, wd, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rdchk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // A hang is cut short at 10000 cycles, well past the few hundred cycles the tests need.
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    e_en1 = 8'h7f;
    e_v1 = rnd();
    e_en3 = 8'hff;
    e_v3 = rnd();
    rdchk(8'h00, 8'hff);
    rdchk(8'h0b, 8'h00);
    rdchk(8'h09, 8'h00);
    rdchk(8'h01, {1'b0, e_v1[6:0]});
    rdchk(8'h02, 8'hff);
    rdchk(8'h0a, 8'h00);
    rdchk(8'h03, e_v3);
    chk(port0_pin_oe | port3_pin_oe | {1'b0, port1_pin_oe}, 8'h00);
    $display("test reset done");
    // Port 0: random latch and drive type, then the input set-up.
    repeat (8) begin
      l = rnd();
      t = rnd();
      e_en0 = 8'h00;
      wr(8'h00, l);
      wr(8'h0b, t);
      rdchk(8'h00, l);
      chk(port0_pin_oe, t | ~l);
      chk(port0_pin_out, t & l);
      rdchk(8'h0c, l);
      wr(8'h00, 8'hff);
      wr(8'h0b, 8'h00);
      e_en0 = 8'hff;
      e_v0 = rnd();
      rdchk(8'h0c, e_v0);
      rdchk(8'h00, 8'hff);
    end
    $display("test port0 done");
    // Port 1: direction, latch and the interrupt-zero release of bit 0.
    repeat (8) begin
      l = rnd();
      d = rnd() & 8'h7f;
      irq_zero_pin_enable = l[7];
      wr(8'h01, l);
      wr(8'h09, d);
      e_en1 = ~d;
      e_v1 = rnd();
      t = d & {7'h7f, ~l[7]};
      chk({1'b0, port1_pin_oe}, t);
      chk({1'b0, port1_pin_out}, l & 8'h7f);
      rdchk(8'h09, d);
      rdchk(8'h01, lev(t, l, ~d, e_v1) & 8'h7f);
    end
    irq_zero_pin_enable = 1'b0;
    $display("test port1 done");
    // Port 2: open-drain latch, stop release and the undefined upper bits.
    repeat (6) begin
      l = rnd();
      stop_mode = l[7];
      wr(8'h02, l);
      t = {5'h00, ~l[2:0] & {2'b11, ~l[7]}};
      chk({5'h00, port2_pin_oe}, t);
      chk({5'h00, port2_pin_out}, 8'h00);
      rdchk(8'h02, {5'h1f, l[2:0]});
      rdchk(8'h0d, lev(t, 8'h00, 8'h00, 8'h00));
    end
    stop_mode = 1'b0;
    $display("test port2 done");
    // Port 3: direction, latch and a converter-owned pin.
    repeat (10) begin
      l = rnd();
      d = rnd();
      c0 = rnd();
      analog_input_disable = c0[7];
      analog_channel_select = c0[3:0];
      am = (!c0[7] && c0[3:0] < 4'h8) ? (8'h01 << c0[2:0]) : 8'h00;
      wr(8'h03, l);
      wr(8'h0a, d);
      e_en3 = ~d | am;
      e_v3 = rnd();
      chk(port3_pin_oe, d & ~am);
      chk(port3_pin_out & ~am, l & ~am);
      rdchk(8'h0a, d);
      rdchk(8'h03, (am & l) | (~am & lev(d & ~am, l, ~d | am, e_v3)));
    end
    analog_input_disable = 1'b1;
    $display("test port3 done");
    // Addresses without a port register read as zero.
    for (int i = 0; i < 8; i++) begin
      rdchk(8'h04 + (8'(i) << 3) + (i > 0 ? 8'h06 : 8'h00), 8'h00);
    end
    rdchk(8'h40, 8'h00);
    rdchk(8'hff, 8'h00);
    $display("test unmapped done");
    // Edge flags from pins driven as outputs.
    wr(8'h01, 8'h00);
    wr(8'h09, 8'h02);
    wr(8'h02, 8'hff);
    repeat (4) @(negedge core_clk);
    c0 = cnt1;
    t = cnt2;
    wr(8'h01, 8'h02);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hfe);
    wr(8'h02, 8'hff);
    repeat (4) @(negedge core_clk);
    chk(cnt1 - c0, 8'h02);
    chk(cnt2 - t, 8'h01);
    $display("test edges done");
    wrap_up();
  end
endmodule : parallel_io_ports_tb
`default_nettype wire
